/* File: fsps_pkg.sv */
package fsps_pkg;

   // ==========================================================
   // Register map (byte addresses on the bus)
   // ==========================================================
   localparam logic [7:0]  ADDR_CTRL     = 8'h00;
   localparam logic [7:0]  ADDR_POINTER  = 8'h04;
   localparam logic [7:0]  ADDR_DATA     = 8'h08;
   localparam logic [7:0]  ADDR_STATUS   = 8'h0C;
   localparam logic [7:0]  ADDR_LOCKS    = 8'h10;
   localparam logic [7:0]  ADDR_STORE    = 8'h14;
   localparam logic [7:0]  ADDR_EEWRITE  = 8'h18;

   // ==========================================================
   // Control register fields
   // ==========================================================
   localparam int          BIT_OPEN      = 0;
   localparam int          BIT_ERASE     = 1;
   localparam int          BIT_WRITE     = 2;
   localparam int          BIT_LOCKSET   = 3;
   localparam int          BIT_REENABLE  = 4;
   localparam int          BIT_BUSY      = 6;
   localparam int          BIT_IRQ_EN    = 7;
   localparam logic [7:0]  CMD_LOAD      = 8'h01;
   localparam logic [7:0]  CMD_ERASE     = 8'h03;
   localparam logic [7:0]  CMD_WRITE     = 8'h05;
   localparam logic [7:0]  CMD_LOCK      = 8'h09;
   localparam logic [7:0]  CMD_REENABLE  = 8'h11;
   localparam logic [4:0]  CMD_MASK      = 5'h1F;

   // ==========================================================
   // Flash geometry
   // ==========================================================
   localparam int          WORD_LSB      = 1;
   localparam int          WORD_MSB      = 5;
   localparam int          PAGE_LSB      = 6;
   localparam int          PAGE_MSB      = 14;
   localparam int          BUF_WORDS     = 32;
   localparam logic [8:0]  NON_REWRITABLE_SECTION_FIRST_PG = 9'h1C0;
   localparam int          LOCK_BITS     = 6;
   localparam logic [5:0]  LOCK_RESET    = 6'h3F;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int          ARM_CYCLES    = 4;
   localparam logic [2:0]  ARM_COUNT     = 3'h4;
   localparam int          CLK_MHZ       = 200;
   localparam int          PROG_MIN_US   = 3700;
   localparam int          PROG_MAX_US   = 4500;
   localparam int          PROG_CYCLES   = PROG_MIN_US * CLK_MHZ;

   typedef enum logic [1:0]
   {
      FSPS_IDLE  = 2'b00,
      FSPS_PROG  = 2'b01,
      FSPS_DONE  = 2'b10
   } fsps_state_t;

   typedef enum logic [1:0]
   {
      FSPS_OP_ERASE = 2'b00,
      FSPS_OP_WRITE = 2'b01,
      FSPS_OP_LOCK  = 2'b10
   } fsps_op_t;

endpackage : fsps_pkg

/* File: fsps_sequencer.sv */
// Our own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
// Notes on behaviour
// - Store target address comes from the 16-bit pointer, bits 14-1.
// - Low address bits pick the word in a page, high bits the page.
// - Address is latched at operation start; later pointer writes have no effect.
// - Lock setting ignores the pointer completely.
// - Program reads are bytewise; read address bit 0 picks the byte.
// - Buffer words may be loaded in any order.
// - Erase pattern plus store within four cycles erases pointer's page.
// - Work on rewritable section keeps other readable; else CPU halts.
// - Load pattern plus store writes data pair to buffer word [5:1].
// - Buffer clears after page write, re-enable write, and reset.
// - Each buffer word takes one load between buffer erasures.
// - A data-EEPROM write during loading discards loaded words.
// - Write pattern plus store programs pointer's page from buffer.
// - Enabled interrupt stays asserted while operation-enable bit is clear.
// - Rewritable section reads blocked during any erase or write.
// - Busy flag set whole time rewritable section busy or blocked.
// - Software clears busy flag by writing re-enable before reuse.
// - Lock pattern plus store programs lock bits whose data bit is zero.
// - Whole flash stays readable while lock bits are programmed.
// - Armed command self-clears if no store within four cycles.
// - Erase, write and lock take the programming time, 3.7 to 4.5 ms.
module fsps_sequencer
   import fsps_pkg::*;
#(
   parameter int PROG_TIME = PROG_CYCLES
)
(
   input  wire logic        clock_i,
   input  wire logic        rst_n_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic      [31:0] hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   input  wire logic        rd_req_i,
   input  wire logic [15:0] rd_addr_i,
   output logic      [7:0]  rd_data_o,
   output logic             rd_blocked_o,
   output logic             cpu_halt_o,
   output logic             irq_o,
   output logic             flash_start_o,
   output logic      [1:0]  flash_op_o,
   output logic      [8:0]  flash_page_o,
   output logic      [5:0]  lock_bits_o
);

   // ==========================================================
   // Bus address phase capture
   // ==========================================================
   logic        wr_pend;
   logic        rd_pend;
   logic [7:0]  ph_addr;
   logic        ad_valid;

   assign ad_valid    = hsel_i && hready_i && htrans_i[1];
   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         ph_addr <= 8'h00;
      end
      else
      begin
         wr_pend <= ad_valid && hwrite_i;
         rd_pend <= ad_valid && !hwrite_i;
         if (ad_valid)
            ph_addr <= haddr_i[7:0];
      end
   end

   logic wr_ctrl;
   logic wr_ptr;
   logic wr_data;
   logic store_ev;
   logic ee_write;

   assign wr_ctrl  = wr_pend && (ph_addr == ADDR_CTRL);
   assign wr_ptr   = wr_pend && (ph_addr == ADDR_POINTER);
   assign wr_data  = wr_pend && (ph_addr == ADDR_DATA);
   assign store_ev = wr_pend && (ph_addr == ADDR_STORE);
   assign ee_write = wr_pend && (ph_addr == ADDR_EEWRITE);

   // ==========================================================
   // Pointer and data pair
   // ==========================================================
   logic [15:0] pointer;
   logic [15:0] data_pair;

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
         pointer <= 16'h0000;
      else if (wr_ptr)
         pointer <= hwdata_i[15:0];
   end

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
         data_pair <= 16'h0000;
      else if (wr_data)
         data_pair <= hwdata_i[15:0];
   end

   // ==========================================================
   // Command arming
   // ==========================================================
   fsps_state_t state;
   logic [4:0]  cmd;
   logic [2:0]  arm_cnt;
   logic        irq_en;
   logic        busy;
   logic        armed;
   logic        go_load;
   logic        go_erase;
   logic        go_write;
   logic        go_lock;
   logic        go_reen;

   assign armed    = cmd[BIT_OPEN] && (arm_cnt != 3'h0) && (state == FSPS_IDLE);
   assign go_load  = store_ev && armed && ({3'h0, cmd} == CMD_LOAD);
   assign go_erase = store_ev && armed && ({3'h0, cmd} == CMD_ERASE);
   assign go_write = store_ev && armed && ({3'h0, cmd} == CMD_WRITE);
   assign go_lock  = store_ev && armed && ({3'h0, cmd} == CMD_LOCK);
   assign go_reen  = store_ev && armed && ({3'h0, cmd} == CMD_REENABLE);

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         cmd     <= 5'h00;
         arm_cnt <= 3'h0;
      end
      else if (wr_ctrl && state == FSPS_IDLE)
      begin
         cmd     <= hwdata_i[4:0] & CMD_MASK;
         arm_cnt <= ARM_COUNT;
      end
      else if (go_load || go_reen || state == FSPS_DONE)
      begin
         cmd     <= 5'h00;
         arm_cnt <= 3'h0;
      end
      // An erase, write or lock store on the last armed cycle must keep the enable bit up
      else if (state == FSPS_IDLE && arm_cnt != 3'h0 && !(go_erase || go_write || go_lock))
      begin
         arm_cnt <= arm_cnt - 3'h1;
         if (arm_cnt == 3'h1)
            cmd <= 5'h00;
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
         irq_en <= 1'b0;
      else if (wr_ctrl)
         irq_en <= hwdata_i[BIT_IRQ_EN];
   end

   // Level interrupt while enable bit clear
   assign irq_o = irq_en && !cmd[BIT_OPEN];

   // ==========================================================
   // Temporary page buffer
   // ==========================================================
   logic [15:0] buf_mem [BUF_WORDS];
   logic [31:0] buf_full;
   logic [4:0]  word_sel;
   logic        buf_clear;
   fsps_op_t    op;

   assign word_sel  = pointer[WORD_MSB:WORD_LSB];
   assign buf_clear = go_reen || ee_write || (state == FSPS_DONE && op == FSPS_OP_WRITE);

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
         buf_full <= 32'h0000_0000;
      else if (buf_clear)
         buf_full <= 32'h0000_0000;
      else if (go_load)
         buf_full[word_sel] <= 1'b1;
   end

   always_ff @(posedge clock_i)
   begin
      if (go_load && !buf_full[word_sel])
         buf_mem[word_sel] <= data_pair;
   end

   // ==========================================================
   // Programming sequence
   // ==========================================================
   logic [8:0]  page_lat;
   logic [22:0] timer;
   logic        non_rewritable_section_tgt;

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         state    <= FSPS_IDLE;
         op       <= FSPS_OP_ERASE;
         page_lat <= 9'h000;
         timer    <= 23'h000000;
      end
      else
      begin
         unique case (state)
            FSPS_IDLE:
            begin
               if (go_erase || go_write || go_lock)
               begin
                  state <= FSPS_PROG;
                  timer <= 23'(PROG_TIME - 1);
                  op    <= go_erase ? FSPS_OP_ERASE :
                           go_write ? FSPS_OP_WRITE : FSPS_OP_LOCK;
                  if (!go_lock)
                     page_lat <= pointer[PAGE_MSB:PAGE_LSB];
               end
            end
            FSPS_PROG:
            begin
               if (timer == 23'h000000)
                  state <= FSPS_DONE;
               else
                  timer <= timer - 23'h000001;
            end
            FSPS_DONE:
               state <= FSPS_IDLE;
            default:
               state <= FSPS_IDLE;
         endcase
      end
   end

   assign non_rewritable_section_tgt = (page_lat >= NON_REWRITABLE_SECTION_FIRST_PG);

   // ==========================================================
   // Lock bits and flash control outputs
   // ==========================================================
   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
         lock_bits_o <= LOCK_RESET;
      else if (state == FSPS_DONE && op == FSPS_OP_LOCK)
         lock_bits_o <= lock_bits_o & data_pair[LOCK_BITS-1:0];
   end

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         flash_start_o <= 1'b0;
         flash_op_o    <= 2'b00;
         flash_page_o  <= 9'h000;
      end
      else
      begin
         flash_start_o <= go_erase || go_write || go_lock;
         // Op and page hold between starts, so pointer reuse cannot disturb a run
         if (go_erase || go_write || go_lock)
            flash_op_o <= go_erase ? 2'(FSPS_OP_ERASE) :
                          go_write ? 2'(FSPS_OP_WRITE) : 2'(FSPS_OP_LOCK);
         if (go_erase || go_write)
            flash_page_o <= pointer[PAGE_MSB:PAGE_LSB];
      end
   end

   // ==========================================================
   // Section busy and read blocking
   // ==========================================================
   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
         busy <= 1'b0;
      else if (go_erase || go_write)
         busy <= 1'b1;
      else if (go_reen && state == FSPS_IDLE)
         busy <= 1'b0;
   end

   logic prog_rw;
   assign prog_rw = (state == FSPS_PROG) && (op != FSPS_OP_LOCK);

   assign rd_blocked_o = busy;
   assign cpu_halt_o   = prog_rw && non_rewritable_section_tgt;

   // ==========================================================
   // Program read port
   // ==========================================================
   logic [4:0]  rd_word_sel;
   logic [15:0] rd_word;

   assign rd_word_sel = rd_addr_i[WORD_MSB:WORD_LSB];
   // Unloaded buffer words read as erased flash
   assign rd_word     = buf_full[rd_word_sel] ? buf_mem[rd_word_sel] : 16'hFFFF;

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
         rd_data_o <= 8'h00;
      // Blocked reads hold the last byte rather than expose a busy section
      else if (rd_req_i && !busy)
         rd_data_o <= rd_addr_i[0] ? rd_word[15:8] : rd_word[7:0];
   end

   // ==========================================================
   // Register read
   // ==========================================================
   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
         hrdata_o <= 32'h0000_0000;
      else if (ad_valid && !hwrite_i)
      begin
         unique case (haddr_i[7:0])
            ADDR_CTRL:    hrdata_o <= {24'h0, irq_en, busy, 1'b0, cmd};
            ADDR_POINTER: hrdata_o <= {16'h0, pointer};
            ADDR_DATA:    hrdata_o <= {16'h0, data_pair};
            ADDR_STATUS:  hrdata_o <= {28'h0, prog_rw, non_rewritable_section_tgt, 2'(state)};
            ADDR_LOCKS:   hrdata_o <= {26'h0, lock_bits_o};
            default:      hrdata_o <= 32'h0000_0000;
         endcase
      end
   end

endmodule : fsps_sequencer

/* File: fsps_sequencer_sva.sv */
`timescale 1ns/1ps
// ========================================
// Port checker
// ========================================
module fsps_sequencer_sva
   import fsps_pkg::*;
(
   input wire logic       clock_i,
   input wire logic       rst_n_i,
   input wire logic       hreadyout_o,
   input wire logic       hresp_o,
   input wire logic       rd_blocked_o,
   input wire logic       cpu_halt_o,
   input wire logic       irq_o,
   input wire logic       flash_start_o,
   input wire logic [1:0] flash_op_o,
   input wire logic [8:0] flash_page_o,
   input wire logic [5:0] lock_bits_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   wire prog_go = flash_start_o && (flash_op_o != FSPS_OP_LOCK);
   wire lock_go = flash_start_o && (flash_op_o == FSPS_OP_LOCK);
   property p_bus_ok;
      hreadyout_o && !hresp_o;
   endproperty
   a_bus_ok: assert property (p_bus_ok) else $error("bus answer not ready or not OKAY");
   property p_op_len;
      flash_start_o |=> !flash_start_o [*8];
   endproperty
   a_op_len: assert property (p_op_len) else $error("operation restarted too soon");
   property p_blk_start;
      prog_go |-> ##[0:1] rd_blocked_o;
   endproperty
   a_blk_start: assert property (p_blk_start) else $error("reads not blocked");
   property p_halt_hi;
      prog_go && (flash_page_o >= NON_REWRITABLE_SECTION_FIRST_PG) |-> ##[0:1] cpu_halt_o;
   endproperty
   a_halt_hi: assert property (p_halt_hi) else $error("core not halted");
   property p_halt_lo;
      prog_go && (flash_page_o < NON_REWRITABLE_SECTION_FIRST_PG) |=> !cpu_halt_o [*4];
   endproperty
   a_halt_lo: assert property (p_halt_lo) else $error("core halted on low page");
   property p_halt_busy;
      cpu_halt_o |-> rd_blocked_o;
   endproperty
   a_halt_busy: assert property (p_halt_busy) else $error("halt without busy");
   property p_lock_read;
      lock_go && !rd_blocked_o |-> (!rd_blocked_o && !cpu_halt_o) [*4];
   endproperty
   a_lock_read: assert property (p_lock_read) else $error("flash blocked by lock");
   property p_irq_run;
      flash_start_o |-> !irq_o;
   endproperty
   a_irq_run: assert property (p_irq_run) else $error("irq while running");
   property p_lock_mono;
      $past(rst_n_i) |-> (lock_bits_o & ~$past(lock_bits_o)) == 6'h00;
   endproperty
   a_lock_mono: assert property (p_lock_mono) else $error("lock bit returned");
   property p_page_hold;
      $changed(flash_page_o) && $past(rst_n_i) |-> flash_start_o;
   endproperty
   a_page_hold: assert property (p_page_hold) else $error("page moved mid-run");
endmodule : fsps_sequencer_sva

bind fsps_sequencer fsps_sequencer_sva sva_u (.clock_i(clock_i), .rst_n_i(rst_n_i),
   .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .rd_blocked_o(rd_blocked_o),
   .cpu_halt_o(cpu_halt_o), .irq_o(irq_o), .flash_start_o(flash_start_o),
   .flash_op_o(flash_op_o), .flash_page_o(flash_page_o), .lock_bits_o(lock_bits_o));

/* File: fsps_cpu_model.sv */
`timescale 1ns/1ps
// ========================================
// Program fetch side of the core
// ========================================
module fsps_cpu_model
(
   input  wire logic        clock_i,
   output logic             rd_req_o,
   output logic      [15:0] rd_addr_o
);
   initial
   begin
      rd_req_o  = 1'b0;
      rd_addr_o = 16'hA5A5;
   end
   task automatic fetch(input logic [15:0] a);
      rd_req_o  <= 1'b1;
      rd_addr_o <= a;
      @(posedge clock_i);
      rd_req_o  <= 1'b0;
      // Released address inverted so a stale value never matches
      rd_addr_o <= ~a;
   endtask : fetch
endmodule : fsps_cpu_model

/* File: flash_self_program_sequencer_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("Error %s expected %0h seen %0h", nm, e, g); end end
module flash_self_program_sequencer_tb
   import fsps_pkg::*;
;
   logic        clock_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic [31:0] haddr   = 32'h0;
   logic [1:0]  htrans  = 2'h0;
   logic        hwrite  = 1'b0;
   logic [31:0] hwdata  = 32'h0;
   logic [31:0] hrdata;
   logic        hready, hresp, rd_req, rd_blocked, halt, irq, fstart;
   logic [15:0] rd_addr;
   logic [7:0]  rd_data;
   logic [1:0]  fop, cap_op;
   logic [8:0]  fpage, cap_pg;
   logic [5:0]  lock_bits;
   int          mismatches = 0;
   int          n_checks   = 0;
   int          n_start    = 0;
   int          cycles     = 0;
   always #2.5 clock_i = ~clock_i;
   fsps_sequencer #(.PROG_TIME(20)) dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i),
      .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
      .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
      .hreadyout_o(hready), .hresp_o(hresp), .rd_req_i(rd_req), .rd_addr_i(rd_addr),
      .rd_data_o(rd_data), .rd_blocked_o(rd_blocked), .cpu_halt_o(halt), .irq_o(irq),
      .flash_start_o(fstart), .flash_op_o(fop), .flash_page_o(fpage),
      .lock_bits_o(lock_bits));
   fsps_cpu_model cpu_u (.clock_i(clock_i), .rd_req_o(rd_req), .rd_addr_o(rd_addr));
   always @(posedge clock_i)
      if (fstart === 1'b1)
      begin
         cap_op  <= fop;
         cap_pg  <= fpage;
         n_start <= n_start + 1;
      end
   // ========================================
   // Bus tasks
   // ========================================
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      haddr  <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clock_i); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock_i); while (hready !== 1'b1);
      q = hrdata;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask : wr
   task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] e);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0, q);
      `CHK(nm, e, q & m)
   endtask : chk_rd
   // Store must follow the arm within four cycles
   task automatic cmd(input logic [7:0] p);
      wr(ADDR_CTRL, {24'h000000, p});
      wr(ADDR_STORE, 32'h0);
   endtask : cmd
   task automatic load(input logic [15:0] z, input logic [15:0] d);
      wr(ADDR_POINTER, {16'h0000, z});
      wr(ADDR_DATA, {16'h0000, d});
      cmd(CMD_LOAD);
   endtask : load
   task automatic wait_done();
      logic [31:0] q;
      q = 32'h1;
      for (int i = 0; i < 100 && q[BIT_OPEN] !== 1'b0; i++)
         xfer(1'b0, ADDR_CTRL, 32'h0, q);
      `CHK("enable bit", 1'b0, q[BIT_OPEN])
   endtask : wait_done
   task automatic chk_fetch(input logic [15:0] a, input logic [7:0] e);
      cpu_u.fetch(a);
      #1;
      `CHK("fetch byte", e, rd_data)
      @(posedge clock_i);
   endtask : chk_fetch
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : final_report
   always @(posedge clock_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         mismatches++;
         final_report();
      end
   end
   // ========================================
   // Tests
   // ========================================
   initial
   begin
      repeat (5) @(posedge clock_i);
      rst_n_i <= 1'b1;
      chk_rd("ctrl", ADDR_CTRL, 32'hFF, 32'h0);
      chk_rd("locks", ADDR_LOCKS, 32'h3F, 32'h3F);
      chk_rd("unmapped", 8'h1C, 32'hFFFFFFFF, 32'h0);
      chk_fetch(16'h000A, 8'hFF);
      $display("test reset done");
      load(16'h000A, 16'h1234);
      load(16'h0004, 16'hBEEF);
      load(16'h000A, 16'h5A5A);
      chk_fetch(16'h000A, 8'h34);
      chk_fetch(16'h000B, 8'h12);
      chk_fetch(16'h0004, 8'hEF);
      wr(ADDR_EEWRITE, 32'h0);
      chk_fetch(16'h0004, 8'hFF);
      $display("test buffer done");
      wr(ADDR_POINTER, 32'h000000C6);
      cmd(CMD_ERASE | 8'h80);
      wr(ADDR_POINTER, 32'h00007FC0);
      #1;
      `CHK("erase page", 9'h003, cap_pg)
      `CHK("blocked", 1'b1, rd_blocked)
      `CHK("irq running", 1'b0, irq)
      @(posedge clock_i);
      wait_done();
      #1;
      `CHK("irq done", 1'b1, irq)
      @(posedge clock_i);
      chk_rd("busy", ADDR_CTRL, 32'hC1, 32'hC0);
      cmd(CMD_REENABLE | 8'h80);
      wait_done();
      #1;
      `CHK("blocked", 1'b0, rd_blocked)
      @(posedge clock_i);
      wr(ADDR_CTRL, 32'h0);
      #1;
      `CHK("irq off", 1'b0, irq)
      @(posedge clock_i);
      $display("test erase done");
      wr(ADDR_POINTER, 32'h00007140);
      cmd(CMD_ERASE);
      @(posedge clock_i);
      #1;
      `CHK("halt", 1'b1, halt)
      @(posedge clock_i);
      wait_done();
      load(16'h0002, 16'hCAFE);
      // Page field again, word bits zero
      wr(ADDR_POINTER, 32'h00007140);
      cmd(CMD_WRITE);
      @(posedge clock_i);
      #1;
      `CHK("write op", FSPS_OP_WRITE, cap_op)
      `CHK("write page", 9'h1C5, cap_pg)
      @(posedge clock_i);
      wait_done();
      cmd(CMD_REENABLE);
      wait_done();
      chk_fetch(16'h0002, 8'hFF);
      $display("test write done");
      wr(ADDR_POINTER, 32'h0000FFFF);
      wr(ADDR_DATA, 32'h0000FFE5);
      cmd(CMD_LOCK);
      @(posedge clock_i);
      #1;
      `CHK("lock read", 1'b0, rd_blocked)
      `CHK("lock page", 9'h1C5, fpage)
      @(posedge clock_i);
      wait_done();
      chk_rd("locks", ADDR_LOCKS, 32'h3F, 32'h25);
      `CHK("lock pins", 6'h25, lock_bits)
      $display("test lock done");
      wr(ADDR_CTRL, {24'h000000, CMD_ERASE});
      repeat (6) @(posedge clock_i);
      wr(ADDR_STORE, 32'h0);
      chk_rd("armed", ADDR_CTRL, 32'h0F, 32'h0);
      `CHK("starts", 4, n_start)
      $display("test arm done");
      load(16'h0006, 16'h7E7E);
      chk_fetch(16'h0006, 8'h7E);
      rst_n_i <= 1'b0;
      @(posedge clock_i);
      rst_n_i <= 1'b1;
      chk_fetch(16'h0006, 8'hFF);
      chk_rd("ctrl after reset", ADDR_CTRL, 32'hFF, 32'h0);
      $display("test mid reset done");
      final_report();
   end
endmodule : flash_self_program_sequencer_tb
